// [dv/edq_dev_model.sv]
`timescale 1ns/10ps
module edq_dev_model (
   // Device bus, slave side
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [31:0] paddr, pwdata,
   output logic [31:0]     prdata,
   output logic            pready, pslverr
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] done [16] = '{default: 32'h0};
   logic        slow, waited;
   function automatic logic [31:0] mr(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : 32'h0;
   endfunction : mr
   // Channel raw state: completed differs from stored ack
   function automatic logic [31:0] rd(input logic [31:0] a);
      logic [31:0] r = 32'h0;
      for (int n = 0; n < 8; n++) begin
         r[n] = done[n] != mr(32'h640 + 4 * n);
         r[n + 16] = done[n + 8] != mr(32'h660 + 4 * n);
      end
      if (a == edq_pkg::DEV_TX_UNMASKED) return {24'h0, r[7:0]};
      if (a == edq_pkg::DEV_RX_UNMASKED) return {24'h0, r[23:16]};
      if (a >= 32'h640 && a < 32'h680) return done[(a - 32'h640) >> 2];
      return mr(a);
   endfunction : rd
   // Alternate prompt and one-wait answers
   assign pready = penable && (!slow || waited);
   // Nothing lives at 00ff_xxxx: such accesses answer with an error
   assign pslverr = pready && paddr[31:16] == 16'h00ff;
   // Released bus shows a toggling pattern
   always @(posedge pclk) begin
      waited <= presetn && penable && !pready;
      prdata <= !presetn ? 32'h0 : (psel && !pwrite) ? rd(paddr) : ~prdata;
      if (!presetn) slow <= 1'b0;
      else if (pready) slow <= ~slow;
      if (pready && pwrite) mem[paddr] = pwdata;
   end
   // Device completes one packet, optionally having missed the link
   task automatic finish(input int ch, input logic [31:0] d, input logic miss);
      logic [31:0] f;
      f = mr(d + 32'hc) & ~(32'h1 << edq_pkg::HOLDS_BIT);
      if (miss || mr(d) == 32'h0) f[edq_pkg::LIST_END_BIT] = 1'b1;
      mem[d + 32'hc] = f;
      done[ch] = d; // Only after write-back
   endtask : finish
endmodule : edq_dev_model

// [dv/edq_host_ctrl_checker.sv]
`timescale 1ns/10ps
module edq_host_ctrl_checker (
   // Software side
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   // Device side
   input wire logic        m_psel, m_penable, m_pwrite, m_pready, m_pslverr,
   input wire logic [31:0] m_paddr, m_pwdata, m_prdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Software port: no waits, unmapped words flagged
   AST_READY: assert property (psel |-> pready) else $error("slave stalled");
   AST_UNMAP: assert property (psel && penable && paddr > 8'h20 |-> pslverr) else $error("unmapped ok");
   AST_MAPOK: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped flagged");
   // Device bus phases; hold until ready, then a gap
   AST_SETUP: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable) else $error("no setup");
   AST_ENSEL: assert property (m_penable |-> m_psel) else $error("enable alone");
   AST_HOLD: assert property (m_penable && !m_pready |=> m_penable && $stable(m_paddr) && $stable(m_pwdata))
      else $error("request moved");
   AST_GAP: assert property (m_penable && m_pready |=> !m_psel) else $error("no idle gap");
   // Descriptors above 2000h are whole packets handed over
   AST_FLAGS: assert property (m_psel && m_pwrite && m_paddr >= 32'h2000 && m_paddr[3:0] == 4'hc
      |-> m_pwdata[31:28] == 4'he) else $error("bad flags");
   // Main scenarios
   cover property (m_penable && !m_pready);
   cover property (psel && pslverr);
   cover property (m_psel && m_pwrite && m_paddr[3:0] == 4'hc);
endmodule : edq_host_ctrl_checker
bind edq_host_ctrl edq_host_ctrl_checker chk_u (.*);

// [dv/edq_host_ctrl_tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module edq_host_ctrl_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv, m_paddr, m_pwdata, m_prdata;
   logic        m_psel, m_penable, m_pwrite, m_pready, m_pslverr;
   int          fail_count = 0, checks = 0, cycles = 0;
   edq_host_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_paddr(m_paddr),
      .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite), .m_pwdata(m_pwdata), .m_prdata(m_prdata),
      .m_pready(m_pready), .m_pslverr(m_pslverr));
   edq_dev_model dev_u (.pclk(pclk), .presetn(presetn), .psel(m_psel), .penable(m_penable), .pwrite(m_pwrite),
      .paddr(m_paddr), .pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready), .pslverr(m_pslverr));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Watchdog on the whole run
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize;
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus
   // Poll status until the sequencer is free
   task automatic cmd(input logic [31:0] c);
      bus(1'b1, edq_pkg::REG_CTRL, c);
      do bus(1'b0, edq_pkg::REG_STATUS, 32'h0); while (rv[edq_pkg::ST_BUSY_BIT] !== 1'b0);
   endtask : cmd
   task automatic queue(input logic [31:0] ch, input logic [31:0] d, input logic [31:0] l);
      bus(1'b1, edq_pkg::REG_Q_CHAN, ch);
      bus(1'b1, edq_pkg::REG_Q_DESC, d);
      bus(1'b1, edq_pkg::REG_Q_BUF, d + 32'h4000);
      bus(1'b1, edq_pkg::REG_Q_LEN, l);
      cmd(32'h4);
   endtask : queue
   task automatic summarize;
      $display("fail_count=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1)
      // Queue before init refused
      cmd(32'h4);
      `CHK(rv[3:0], 4'h4)
      bus(1'b1, edq_pkg::REG_STATUS, 32'h4);
      // Init clears stale heads, loads enables and gate
      for (int n = 0; n < 16; n++) dev_u.mem[32'h600 + 4 * n] = 32'hdead;
      bus(1'b1, edq_pkg::REG_IRQ_EN, 32'ha5f3);
      cmd(32'h1);
      `CHK(rv[3:0], 4'h1)
      for (int n = 0; n < 16; n++) `CHK(dev_u.mr(32'h600 + 4 * n), 32'h0)
      `CHK(dev_u.mr(edq_pkg::DEV_TX_IRQ_SET) ^ dev_u.mr(edq_pkg::DEV_RX_IRQ_SET), 32'h56)
      `CHK(dev_u.mr(edq_pkg::DEV_WRAPPER_CTL), 32'h1)
      // First packet starts tx 2, second is linked on
      queue(2, 32'h2000, 32'h0004_0040);
      `CHK(dev_u.mr(32'h2008), 32'h0004_0040)
      `CHK(dev_u.mr(32'h200c), 32'he000_0040)
      queue(2, 32'h2010, 32'h0000_05ea);
      `CHK(dev_u.mr(32'h2000), 32'h2010)
      `CHK(dev_u.mr(32'h2014), 32'h6010)
      `CHK(dev_u.mr(32'h608), 32'h2000)
      // Device missed the link: service restarts and acknowledges
      dev_u.finish(2, 32'h2000, 1'b1);
      cmd(32'h2);
      `CHK(dev_u.mr(32'h608), 32'h2010)
      `CHK(dev_u.mr(32'h648), 32'h2000)
      // Receive 1 ends normally
      queue(9, 32'h3000, 32'h0000_0600);
      `CHK(dev_u.mr(32'h3000), 32'h0)
      dev_u.finish(9, 32'h3000, 1'b0);
      cmd(32'h2);
      `CHK(dev_u.mr(32'h664), 32'h3000)
      `CHK(dev_u.mr(32'h300c), 32'hd000_0600)
      bus(1'b0, edq_pkg::REG_LAST_ACK, 32'h0);
      `CHK(rv, 32'h0000_3000)
      bus(1'b0, edq_pkg::REG_RAW, 32'h0);
      `CHK(rv, 32'h0004_0000)
      // Idle receive 1 restarts through its head, old tail untouched
      queue(9, 32'h3010, 32'h0000_0100);
      `CHK(dev_u.mr(32'h624), 32'h3010)
      `CHK(dev_u.mr(32'h3000), 32'h0)
      // Device bus error is recorded and cleared by writing one
      queue(3, 32'h00ff_0000, 32'h0000_0010);
      `CHK(rv[3:0], 4'h9)
      bus(1'b1, edq_pkg::REG_STATUS, 32'h8);
      bus(1'b0, edq_pkg::REG_STATUS, 32'h0);
      `CHK(rv[3:0], 4'h1)
      summarize;
   end
endmodule : edq_host_ctrl_tb

// [pkg/edq_pkg.sv]
package edq_pkg;

   // Channel counts
   localparam int CHANNELS     = 8;
   localparam int ALL_CHANNELS = 2 * CHANNELS;

   // Own command registers (byte offsets on the software-facing APB)
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_Q_CHAN   = 8'h08;
   localparam logic [7:0] REG_Q_DESC   = 8'h0c;
   localparam logic [7:0] REG_Q_BUF    = 8'h10;
   localparam logic [7:0] REG_Q_LEN    = 8'h14;
   localparam logic [7:0] REG_IRQ_EN   = 8'h18;
   localparam logic [7:0] REG_LAST_ACK = 8'h1c;
   localparam logic [7:0] REG_RAW      = 8'h20;

   // Command register bits
   localparam int CTRL_INIT_BIT    = 0;
   localparam int CTRL_SERVICE_BIT = 1;
   localparam int CTRL_QUEUE_BIT   = 2;

   // Status register bits
   localparam int ST_READY_BIT   = 0;
   localparam int ST_BUSY_BIT    = 1;
   localparam int ST_REFUSED_BIT = 2;
   localparam int ST_BUS_ERR_BIT = 3;

   // Reset values
   localparam logic [15:0] IRQ_EN_RESET = 16'hffff;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

   // Device register map as seen by this controller
   localparam logic [31:0] DEV_TX_HEAD     = 32'h0000_0600;
   localparam logic [31:0] DEV_RX_HEAD     = 32'h0000_0620;
   localparam logic [31:0] DEV_TX_ACK      = 32'h0000_0640;
   localparam logic [31:0] DEV_RX_ACK      = 32'h0000_0660;
   localparam logic [31:0] DEV_TX_IRQ_SET  = 32'h0000_0108;
   localparam logic [31:0] DEV_RX_IRQ_SET  = 32'h0000_0110;
   localparam logic [31:0] DEV_TX_UNMASKED = 32'h0000_0080;
   localparam logic [31:0] DEV_RX_UNMASKED = 32'h0000_00a0;
   localparam logic [31:0] DEV_WRAPPER_CTL = 32'h0000_1004;
   localparam int          GLOBAL_GATE_BIT = 0;

   // Descriptor layout: four words, sixteen bytes
   localparam logic [31:0] DESC_BYTES    = 32'h0000_0010;
   localparam logic [31:0] DESC_W_NEXT   = 32'h0000_0000;
   localparam logic [31:0] DESC_W_BUF    = 32'h0000_0004;
   localparam logic [31:0] DESC_W_LEN    = 32'h0000_0008;
   localparam logic [31:0] DESC_W_FLAGS  = 32'h0000_000c;
   localparam int          FIRST_FRAG_BIT = 31;
   localparam int          LAST_FRAG_BIT  = 30;
   localparam int          HOLDS_BIT      = 29;
   localparam int          LIST_END_BIT   = 28;

   // One request towards the device
   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic [31:0] wdata;
   } edq_bus_req_t;

   // Sequencer states, Gray along the listed order from ST_IDLE to ST_SV_ACK_WR
   typedef enum logic [4:0] {
      ST_IDLE       = 5'h00,
      ST_INIT_HEAD  = 5'h01,
      ST_INIT_MTX   = 5'h03,
      ST_INIT_MRX   = 5'h02,
      ST_INIT_GATE  = 5'h06,
      ST_Q_W0       = 5'h07,
      ST_Q_W1       = 5'h05,
      ST_Q_W2       = 5'h04,
      ST_Q_W3       = 5'h0c,
      ST_Q_LINK     = 5'h0d,
      ST_SV_RAW_TX  = 5'h0f,
      ST_SV_RAW_RX  = 5'h0e,
      ST_SV_ACK_RD  = 5'h0a,
      ST_SV_FLAGS   = 5'h0b,
      ST_SV_NEXT    = 5'h09,
      ST_SV_RESTART = 5'h08,
      ST_SV_ACK_WR  = 5'h18
   } edq_state_t;

endpackage : edq_pkg

// [src/edq_host_ctrl.sv]
`timescale 1ns/10ps
module edq_host_ctrl #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Software command port, APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device registers and descriptor memory, APB master
   output logic      [31:0] m_paddr,
   output logic             m_psel,
   output logic             m_penable,
   output logic             m_pwrite,
   output logic      [31:0] m_pwdata,
   input  wire logic [31:0] m_prdata,
   input  wire logic        m_pready,
   input  wire logic        m_pslverr
);

   generate
      if (CHANNELS != edq_pkg::CHANNELS) begin : g_bad_channels
         $error("edq_host_ctrl serves exactly eight channels per direction");
      end
   endgenerate

   edq_pkg::edq_state_t   state;
   edq_pkg::edq_bus_req_t req;
   logic                  need_bus;
   logic                  bus_done;
   logic [3:0]            init_idx;
   logic [3:0]            q_chan;
   logic [31:0]           q_desc;
   logic [31:0]           q_buf;
   logic [31:0]           q_len;
   logic [15:0]           irq_en;
   logic [15:0]           active;
   logic [15:0]           raw;
   logic [3:0]            svc_ch;
   logic [31:0]           comp;
   logic [31:0]           next_ptr;
   logic [31:0]           last_ack;
   logic                  init_done;
   logic                  refused;
   logic                  bus_err;
   logic                  sw_wr;
   logic                  sw_setup_rd;
   logic                  mapped;
   logic                  cmd_wr;
   logic                  go_init;
   logic                  go_svc;
   logic                  go_queue;
   logic                  cmd_refused;
   logic [15:0]           raw_all;
   logic [31:0]           tail_rd;
   logic                  tail_wr;
   logic [3:0]            tail_rd_addr;

   // Head and acknowledge addresses of one channel; channels 8..15 are receive
   function automatic logic [31:0] head_addr(input logic [3:0] ch);
      head_addr = (ch[3] ? edq_pkg::DEV_RX_HEAD : edq_pkg::DEV_TX_HEAD) + {27'h0, ch[2:0], 2'b00};
   endfunction : head_addr

   function automatic logic [31:0] ack_addr(input logic [3:0] ch);
      ack_addr = (ch[3] ? edq_pkg::DEV_RX_ACK : edq_pkg::DEV_TX_ACK) + {27'h0, ch[2:0], 2'b00};
   endfunction : ack_addr

   // Lowest pending channel, transmit before receive
   function automatic logic [3:0] lowest(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      lowest = r;
   endfunction : lowest

   // Software port decode
   assign pready      = 1'b1;
   assign sw_wr       = psel & penable & pwrite;
   assign sw_setup_rd = psel & ~penable & ~pwrite;
   assign cmd_wr      = sw_wr & (paddr == edq_pkg::REG_CTRL);
   assign raw_all     = {m_prdata[7:0], raw[7:0]};

   always_comb begin
      if (paddr == edq_pkg::REG_CTRL || paddr == edq_pkg::REG_STATUS) begin
         mapped = 1'b1;
      end else if (paddr == edq_pkg::REG_Q_CHAN || paddr == edq_pkg::REG_Q_DESC) begin
         mapped = 1'b1;
      end else if (paddr == edq_pkg::REG_Q_BUF || paddr == edq_pkg::REG_Q_LEN) begin
         mapped = 1'b1;
      end else if (paddr == edq_pkg::REG_IRQ_EN || paddr == edq_pkg::REG_LAST_ACK) begin
         mapped = 1'b1;
      end else if (paddr == edq_pkg::REG_RAW) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   assign pslverr = psel & penable & ~mapped;

   // Commands start only from idle; queue and service also need a finished init
   assign go_init     = cmd_wr & pwdata[edq_pkg::CTRL_INIT_BIT] & (state == edq_pkg::ST_IDLE);
   assign go_svc      = cmd_wr & pwdata[edq_pkg::CTRL_SERVICE_BIT] & (state == edq_pkg::ST_IDLE)
                        & init_done & ~go_init;
   assign go_queue    = cmd_wr & pwdata[edq_pkg::CTRL_QUEUE_BIT] & (state == edq_pkg::ST_IDLE)
                        & init_done & ~go_init & ~go_svc;
   assign cmd_refused = cmd_wr & (|pwdata[2:0]) & ~go_init & ~go_svc & ~go_queue;

   // Parameter registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_chan <= 4'h0;
         q_desc <= edq_pkg::WORD_RESET;
         q_buf  <= edq_pkg::WORD_RESET;
         q_len  <= edq_pkg::WORD_RESET;
         irq_en <= edq_pkg::IRQ_EN_RESET;
      end else if (sw_wr) begin
         if (paddr == edq_pkg::REG_Q_CHAN) begin
            q_chan <= pwdata[3:0];
         end else if (paddr == edq_pkg::REG_Q_DESC) begin
            q_desc <= pwdata;
         end else if (paddr == edq_pkg::REG_Q_BUF) begin
            q_buf <= pwdata;
         end else if (paddr == edq_pkg::REG_Q_LEN) begin
            q_len <= pwdata;
         end else if (paddr == edq_pkg::REG_IRQ_EN) begin
            irq_en <= pwdata[15:0];
         end
      end
   end

   // Sticky error flags; a new event beats a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused <= 1'b0;
         bus_err <= 1'b0;
      end else begin
         if (cmd_refused) begin
            refused <= 1'b1;
         end else if (sw_wr && paddr == edq_pkg::REG_STATUS && pwdata[edq_pkg::ST_REFUSED_BIT]) begin
            refused <= 1'b0;
         end
         if (bus_done && m_pslverr) begin
            bus_err <= 1'b1;
         end else if (sw_wr && paddr == edq_pkg::REG_STATUS && pwdata[edq_pkg::ST_BUS_ERR_BIT]) begin
            bus_err <= 1'b0;
         end
      end
   end

   // Read data captured in the setup cycle so the access phase needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= edq_pkg::WORD_RESET;
      end else if (sw_setup_rd) begin
         if (paddr == edq_pkg::REG_STATUS) begin
            prdata <= {28'h0, bus_err, refused, state != edq_pkg::ST_IDLE, init_done};
         end else if (paddr == edq_pkg::REG_Q_CHAN) begin
            prdata <= {28'h0, q_chan};
         end else if (paddr == edq_pkg::REG_Q_DESC) begin
            prdata <= q_desc;
         end else if (paddr == edq_pkg::REG_Q_BUF) begin
            prdata <= q_buf;
         end else if (paddr == edq_pkg::REG_Q_LEN) begin
            prdata <= q_len;
         end else if (paddr == edq_pkg::REG_IRQ_EN) begin
            prdata <= {16'h0, irq_en};
         end else if (paddr == edq_pkg::REG_LAST_ACK) begin
            prdata <= last_ack;
         end else if (paddr == edq_pkg::REG_RAW) begin
            prdata <= {active, raw};
         end else begin
            prdata <= edq_pkg::WORD_RESET;
         end
      end
   end

   // Request towards the device for the current step
   always_comb begin
      req      = '0;
      need_bus = 1'b1;
      case (state)
         edq_pkg::ST_INIT_HEAD: begin
            req.addr  = head_addr(init_idx);
            req.write = 1'b1;
         end
         edq_pkg::ST_INIT_MTX: begin
            req.addr  = edq_pkg::DEV_TX_IRQ_SET;
            req.write = 1'b1;
            req.wdata = {24'h0, irq_en[7:0]};
         end
         edq_pkg::ST_INIT_MRX: begin
            req.addr  = edq_pkg::DEV_RX_IRQ_SET;
            req.write = 1'b1;
            req.wdata = {24'h0, irq_en[15:8]};
         end
         edq_pkg::ST_INIT_GATE: begin
            req.addr  = edq_pkg::DEV_WRAPPER_CTL;
            req.write = 1'b1;
            req.wdata = 32'h0000_0001 << edq_pkg::GLOBAL_GATE_BIT;
         end
         edq_pkg::ST_Q_W0: begin
            req.addr  = q_desc + edq_pkg::DESC_W_NEXT;
            req.write = 1'b1;
         end
         edq_pkg::ST_Q_W1: begin
            req.addr  = q_desc + edq_pkg::DESC_W_BUF;
            req.write = 1'b1;
            req.wdata = q_buf;
         end
         edq_pkg::ST_Q_W2: begin
            req.addr  = q_desc + edq_pkg::DESC_W_LEN;
            req.write = 1'b1;
            req.wdata = q_len;
         end
         edq_pkg::ST_Q_W3: begin
            req.addr  = q_desc + edq_pkg::DESC_W_FLAGS;
            req.write = 1'b1;
            req.wdata = {16'h0, q_len[15:0]};
            req.wdata[edq_pkg::FIRST_FRAG_BIT] = 1'b1;
            req.wdata[edq_pkg::LAST_FRAG_BIT]  = 1'b1;
            req.wdata[edq_pkg::HOLDS_BIT]      = 1'b1;
         end
         edq_pkg::ST_Q_LINK: begin
            // Active list: patch the old tail, never touch the head
            req.addr  = active[q_chan] ? tail_rd + edq_pkg::DESC_W_NEXT : head_addr(q_chan);
            req.write = 1'b1;
            req.wdata = q_desc;
         end
         edq_pkg::ST_SV_RAW_TX: begin
            req.addr = edq_pkg::DEV_TX_UNMASKED;
         end
         edq_pkg::ST_SV_RAW_RX: begin
            req.addr = edq_pkg::DEV_RX_UNMASKED;
         end
         edq_pkg::ST_SV_ACK_RD: begin
            req.addr = ack_addr(svc_ch);
         end
         edq_pkg::ST_SV_FLAGS: begin
            req.addr = comp + edq_pkg::DESC_W_FLAGS;
         end
         edq_pkg::ST_SV_NEXT: begin
            req.addr = comp + edq_pkg::DESC_W_NEXT;
         end
         edq_pkg::ST_SV_RESTART: begin
            req.addr  = head_addr(svc_ch);
            req.write = 1'b1;
            req.wdata = next_ptr;
         end
         edq_pkg::ST_SV_ACK_WR: begin
            req.addr  = ack_addr(svc_ch);
            req.write = 1'b1;
            req.wdata = comp;
         end
         default: begin
            need_bus = 1'b0;
         end
      endcase
   end

   // Master side: setup, access, held until pready
   assign bus_done = m_psel & m_penable & m_pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_psel    <= 1'b0;
         m_penable <= 1'b0;
         m_paddr   <= edq_pkg::WORD_RESET;
         m_pwrite  <= 1'b0;
         m_pwdata  <= edq_pkg::WORD_RESET;
      end else if (!m_psel && need_bus) begin
         m_psel   <= 1'b1;
         m_paddr  <= req.addr;
         m_pwrite <= req.write;
         m_pwdata <= req.wdata;
      end else if (m_psel && !m_penable) begin
         m_penable <= 1'b1;
      end else if (bus_done) begin
         m_psel    <= 1'b0;
         m_penable <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= edq_pkg::ST_IDLE;
         init_idx  <= 4'h0;
         init_done <= 1'b0;
         raw       <= 16'h0;
         svc_ch    <= 4'h0;
         comp      <= edq_pkg::WORD_RESET;
         next_ptr  <= edq_pkg::WORD_RESET;
         last_ack  <= edq_pkg::WORD_RESET;
      end else if (state == edq_pkg::ST_IDLE) begin
         if (go_init) begin
            init_idx  <= 4'h0;
            init_done <= 1'b0;
            state     <= edq_pkg::ST_INIT_HEAD;
         end else if (go_svc) begin
            state <= edq_pkg::ST_SV_RAW_TX;
         end else if (go_queue) begin
            state <= edq_pkg::ST_Q_W0;
         end
      end else if (bus_done) begin
         case (state)
            edq_pkg::ST_INIT_HEAD: begin
               init_idx <= init_idx + 4'h1;
               if (init_idx == 4'hf) begin
                  state <= edq_pkg::ST_INIT_MTX;
               end
            end
            edq_pkg::ST_INIT_MTX:  state <= edq_pkg::ST_INIT_MRX;
            edq_pkg::ST_INIT_MRX:  state <= edq_pkg::ST_INIT_GATE;
            edq_pkg::ST_INIT_GATE: begin
               init_done <= 1'b1;
               state     <= edq_pkg::ST_IDLE;
            end
            edq_pkg::ST_Q_W0:   state <= edq_pkg::ST_Q_W1;
            edq_pkg::ST_Q_W1:   state <= edq_pkg::ST_Q_W2;
            edq_pkg::ST_Q_W2:   state <= edq_pkg::ST_Q_W3;
            edq_pkg::ST_Q_W3:   state <= edq_pkg::ST_Q_LINK;       // Link only after full descriptor
            edq_pkg::ST_Q_LINK: state <= edq_pkg::ST_IDLE;
            edq_pkg::ST_SV_RAW_TX: begin
               raw[7:0] <= m_prdata[7:0];
               state    <= edq_pkg::ST_SV_RAW_RX;
            end
            edq_pkg::ST_SV_RAW_RX: begin
               raw[15:8] <= m_prdata[7:0];
               svc_ch    <= lowest(raw_all);
               state     <= (raw_all == 16'h0) ? edq_pkg::ST_IDLE : edq_pkg::ST_SV_ACK_RD;
            end
            edq_pkg::ST_SV_ACK_RD: begin
               comp  <= m_prdata;
               state <= edq_pkg::ST_SV_FLAGS;
            end
            edq_pkg::ST_SV_FLAGS: begin
               // List end with more queued behind it means the device missed them
               if (m_prdata[edq_pkg::LIST_END_BIT] && comp != tail_rd) begin
                  state <= edq_pkg::ST_SV_NEXT;
               end else begin
                  state <= edq_pkg::ST_SV_ACK_WR;
               end
            end
            edq_pkg::ST_SV_NEXT: begin
               next_ptr <= m_prdata;
               state    <= (m_prdata != edq_pkg::WORD_RESET) ? edq_pkg::ST_SV_RESTART
                                                               : edq_pkg::ST_SV_ACK_WR;
            end
            edq_pkg::ST_SV_RESTART: state <= edq_pkg::ST_SV_ACK_WR;
            edq_pkg::ST_SV_ACK_WR: begin
               last_ack <= comp;
               state    <= edq_pkg::ST_SV_RAW_TX;                      // Rescan until nothing pending
            end
            default: state <= edq_pkg::ST_IDLE;
         endcase
      end
   end

   // Which channels hold a list the device may still walk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 16'h0;
      end else if (go_init) begin
         active <= 16'h0;
      end else if (bus_done && state == edq_pkg::ST_Q_LINK) begin
         active[q_chan] <= 1'b1;
      end else if (bus_done && state == edq_pkg::ST_SV_FLAGS && m_prdata[edq_pkg::LIST_END_BIT]
                   && comp == tail_rd) begin
         active[svc_ch] <= 1'b0;
      end
   end

   // Tail of each channel's list, needed for appending and list-end checks
   assign tail_wr      = bus_done & (state == edq_pkg::ST_Q_LINK);
   // Registered read port: the queue channel is looked up one step ahead of the link write
   assign tail_rd_addr = (state == edq_pkg::ST_Q_W3 || state == edq_pkg::ST_Q_LINK) ? q_chan : svc_ch;

   edq_tail_mem #(
      .WIDTH (32),
      .DEPTH (edq_pkg::ALL_CHANNELS)
   ) u_tail_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (tail_wr),
      .wr_addr (q_chan),
      .wr_data (q_desc),
      .rd_addr (tail_rd_addr),
      .rd_data (tail_rd)
   );

endmodule : edq_host_ctrl

// [src/edq_tail_mem.sv]
`timescale 1ns/10ps
module edq_tail_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // Write port
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   // Registered read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("edq_tail_mem depth must be a power of two");
      end
   endgenerate

   // Storage array, no reset needed: entries are only read once written
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data leaves through a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule : edq_tail_mem
